// *** verilog/acp_defs.vh ***
// Constants for the converter mode configuration port
// Operation
// - Strap mode: chip-select level turns duty stabilizer off (low) or on (high).
// - Strap mode: serial clock low gives full-rate CMOS, high gives DDR LVDS 3.5mA.
// - Strap mode: serial data low is normal operation, high is sleep.
// - Serial mode: chip select low starts a transfer, high ends it.
// - Only the first 16 serial clock rising edges sample data; later ones ignored.
// - Word is read/write flag, seven address bits, eight data bits, first to last.
// - Flag low writes the data bits into the addressed register.
// - Flag high reads the register back; register unchanged, input data discarded.
// - Serial output is open drain; host supplies the pull-up.
// - Writing one to bit 7 at 00h clears all registers; bit self-clears; write only.
// - Power field at 01h: 00 normal, 01 nap, 11 sleep, 10 unused.
// - Timing bit 3 inverts output clock; bit 0 turns duty stabilizer on.
// - Timing bits 2-1 delay output clock by 0, 1/8, 1/4 or 3/8 period.
// - Driver mode bits 6-4 select differential drive current; 011 unused.
// - Driver mode bit 3 enables internal termination, current becomes 1.6 times.
// - Driver mode bit 2 puts all digital outputs in high impedance.
// - Driver mode bits 1-0: 00 CMOS, 01 DDR LVDS, 10 DDR CMOS, 11 unused.
// - Format bits 5-3 select test patterns: off, zeros, ones, checkerboard, alternating.
// - Format bit 2 odd-bit invert, bit 1 scramble, bit 0 two's complement.
// - Scramble XORs each data bit above the LSB with the LSB.
// - Odd-bit invert inverts odd data bits and forces offset binary.
// - Test pattern overrides two's complement, scramble and odd-bit invert.
`ifndef ACP_DEFS_VH
`define ACP_DEFS_VH
`define ACP_WORD_BITS 5'h10
`define ACP_ADDR_LAST 5'h07
`define ACP_ADDR_RST 7'h00
`define ACP_ADDR_PWR 7'h01
`define ACP_ADDR_TIM 7'h02
`define ACP_ADDR_DRV 7'h03
`define ACP_ADDR_FMT 7'h04
`define ACP_REG_RESET 8'h00
`define ACP_RST_BIT 7
`define ACP_TIM_INV 3
`define ACP_TIM_DLY_HI 2
`define ACP_TIM_DLY_LO 1
`define ACP_TIM_DCS 0
`define ACP_DRV_CUR_HI 6
`define ACP_DRV_CUR_LO 4
`define ACP_DRV_TERM 3
`define ACP_DRV_HIZ 2
`define ACP_DRV_MODE_HI 1
`define ACP_DRV_MODE_LO 0
`define ACP_FMT_TP_HI 5
`define ACP_FMT_TP_LO 3
`define ACP_FMT_ABP 2
`define ACP_FMT_LSB_SCRAMBLE_ENABLE 1
`define ACP_FMT_TWOS 0
`define ACP_PWR_NORMAL 2'h0
`define ACP_PWR_NAP 2'h1
`define ACP_PWR_SLEEP 2'h3
`define ACP_MODE_CMOS 2'h0
`define ACP_MODE_LVDS 2'h1
`define ACP_CUR_DEFAULT 3'h0
`define ACP_TP_OFF 3'h0
`define ACP_TP_ZERO 3'h1
`define ACP_TP_ONE 3'h3
`define ACP_TP_CHECK 3'h5
`define ACP_TP_ALT 3'h7
`define ACP_CHECK_A 13'h1555
`define ACP_ONES 13'h1FFF
`define ACP_ZEROS 13'h0000
`define ACP_ODD_MASK 12'hAAA
`define ACP_MSB_FLIP 12'h800
`endif

// *** verilog/acp_sync.v ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module acp_sync (
  input wire mclk_in,
  input wire srst_in,
  input wire d_in,
  output wire q_out
);
  reg meta_r;
  reg sync_r;
  // =====================================================
  // Synchroniser chain; meta_r is read only by sync_r
  always @(posedge mclk_in) begin
    if (srst_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end
  assign q_out = sync_r;
endmodule // acp_sync

// *** verilog/acp_format.v ***
// Output data formatter: test pattern, two's complement, scramble, odd-bit invert
`timescale 1ns/1ps
`include "acp_defs.vh"
module acp_format (
  input wire mclk_in,
  input wire srst_in,
  input wire sample_valid_in,
  input wire [11:0] sample_in,
  input wire range_overflow_flag_in,
  input wire [2:0] test_pattern_select_in,
  input wire odd_bit_invert_enable_in,
  input wire lsb_scramble_enable_in,
  input wire signed_format_select_in,
  output reg [11:0] fmt_data_out,
  output reg fmt_overflow_out
);
  reg phase_r;
  reg [12:0] pat;
  reg [11:0] d;
  // =====================================================
  // Alternating patterns flip once per sample
  always @(posedge mclk_in) begin
    if (srst_in) begin
      phase_r <= 1'b0;
    end else if (sample_valid_in) begin
      phase_r <= ~phase_r;
    end
  end
  // Pattern select and data coding
  always @* begin
    pat = `ACP_ZEROS;
    case (test_pattern_select_in)
      `ACP_TP_ONE: pat = `ACP_ONES;
      `ACP_TP_CHECK: pat = phase_r ? ~`ACP_CHECK_A : `ACP_CHECK_A;
      `ACP_TP_ALT: pat = phase_r ? `ACP_ONES : `ACP_ZEROS;
      default: pat = `ACP_ZEROS;
    endcase
    d = sample_in;
    // Odd-bit invert forces offset binary
    if (signed_format_select_in && !odd_bit_invert_enable_in) begin
      d = d ^ `ACP_MSB_FLIP;
    end
    if (lsb_scramble_enable_in) begin
      d = d ^ {{11{d[0]}}, 1'b0};
    end
    if (odd_bit_invert_enable_in) begin
      d = d ^ `ACP_ODD_MASK;
    end
  end
  // Registered outputs; an active pattern wins over all coding
  always @(posedge mclk_in) begin
    if (srst_in) begin
      fmt_data_out <= 12'h000;
      fmt_overflow_out <= 1'b0;
    end else if (sample_valid_in) begin
      if (test_pattern_select_in != `ACP_TP_OFF) begin
        fmt_data_out <= pat[11:0];
        fmt_overflow_out <= pat[12];
      end else begin
        fmt_data_out <= d;
        fmt_overflow_out <= range_overflow_flag_in;
      end
    end
  end
endmodule // acp_format

// *** verilog/acp_mode_port.v ***
// Mode configuration port: strap decode, serial register access, mode outputs
`timescale 1ns/1ps
`include "acp_defs.vh"
module acp_mode_port (
  input wire mclk_in,
  input wire srst_in,
  input wire strap_or_serial_select_in,
  input wire cs_n_in,
  input wire sck_in,
  input wire sdi_in,
  output wire sdo_out,
  output reg sdo_oe_out,
  input wire sample_valid_in,
  input wire [11:0] sample_in,
  input wire range_overflow_flag_in,
  output wire [11:0] fmt_data_out,
  output wire fmt_overflow_out,
  output reg [1:0] power_state_field_out,
  output reg duty_stabilizer_enable_out,
  output reg out_clock_invert_out,
  output reg [1:0] out_clock_delay_field_out,
  output reg [2:0] diff_drive_current_field_out,
  output reg internal_termination_enable_out,
  output reg drive_current_boost_out,
  output reg output_high_z_out,
  output reg [1:0] output_interface_select_out
);
  // =====================================================
  // Register map, serial mode
  //   00h soft reset: bit 7 clears every register when the frame ends; reads 00h
  //   01h power state: bits 1-0
  //   02h output clock: bit 3 invert, bits 2-1 delay, bit 0 duty stabilizer
  //   03h output driver: bits 6-4 current, bit 3 termination, bit 2 high-z, bits 1-0 interface
  //   04h data format: bits 5-3 pattern, bit 2 odd-bit invert, bit 1 scramble, bit 0 signed
  //   05h to 7Fh: writes dropped, reads return 00h
  // Unused bits are stored and read back as written
  //
  // Serial timing seen from the host
  //   Every pin passes two flops, so each edge acts three clocks late
  //   Serial clock high and low phases must each last four clocks or more
  //   Chip select must stay high four clocks or more between frames
  //   First read bit follows the eighth rise; the rest change after the ninth to fifteenth falling serial clock edges
  //   Write data lands about four clocks after the sixteenth rise
  //   Soft reset clears about four clocks after chip select rises
  // Unused codes pass through; the output stage decides their effect

  // =====================================================
  // Serial frame states, one-hot
  localparam ST_IDLE = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_DONE = 3'b100;

  wire par_s;
  wire cs_n_s;
  wire sck_s;
  wire sdi_s;
  reg sck_d_r;
  reg cs_d_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [4:0] bit_cnt_r;
  reg [15:0] shift_r;
  reg [7:0] rd_data_r;
  reg rd_active_r;
  reg pending_rst_r;
  reg [7:0] pwr_r;
  reg [7:0] tim_r;
  reg [7:0] drv_r;
  reg [7:0] fmt_r;
  reg [7:0] rd_mux;
  wire cs_act_s;
  wire sck_rise;
  wire sck_fall;
  wire cs_rise;
  wire [15:0] word;
  wire last_bit;
  wire shift_rise;
  wire wr_commit;
  wire soft_clr;
  wire [1:0] strap_iface;
  wire [1:0] strap_power;

  // Register read decode; soft reset register reads zero
  function [7:0] reg_read;
    input [6:0] addr;
    begin
      case (addr)
        `ACP_ADDR_PWR: reg_read = pwr_r;
        `ACP_ADDR_TIM: reg_read = tim_r;
        `ACP_ADDR_DRV: reg_read = drv_r;
        `ACP_ADDR_FMT: reg_read = fmt_r;
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  // =====================================================
  // Pin synchronisers; the serial clock is sampled like any pin
  // No pin is read before its second flop
  acp_sync u_sync_par (.mclk_in(mclk_in), .srst_in(srst_in), .d_in(strap_or_serial_select_in), .q_out(par_s));
  // Chip select runs inverted so that a cleared chain reads as deselected
  acp_sync u_sync_cs (.mclk_in(mclk_in), .srst_in(srst_in), .d_in(~cs_n_in), .q_out(cs_act_s));
  assign cs_n_s = ~cs_act_s;
  acp_sync u_sync_sck (.mclk_in(mclk_in), .srst_in(srst_in), .d_in(sck_in), .q_out(sck_s));
  acp_sync u_sync_sdi (.mclk_in(mclk_in), .srst_in(srst_in), .d_in(sdi_in), .q_out(sdi_s));

  // Edge detection on synchronised levels
  // Reset values equal the idle pin levels, so reset makes no false edge
  always @(posedge mclk_in) begin
    if (srst_in) begin
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
      cs_d_r <= cs_n_s;
    end
  end
  assign sck_rise = sck_s & ~sck_d_r;
  assign sck_fall = ~sck_s & sck_d_r;
  assign cs_rise = cs_n_s & ~cs_d_r;
  assign word = {shift_r[14:0], sdi_s};
  assign last_bit = (bit_cnt_r == `ACP_WORD_BITS - 5'h01);
  // Command strobes
  assign shift_rise = (state_r == ST_SHIFT) && sck_rise;
  assign wr_commit = shift_rise && last_bit && !word[15];
  assign soft_clr = pending_rst_r && cs_rise;

  // Strap pin decode; driver current and termination stay at their defaults
  assign strap_iface = sck_s ? `ACP_MODE_LVDS : `ACP_MODE_CMOS;
  assign strap_power = sdi_s ? `ACP_PWR_SLEEP : `ACP_PWR_NORMAL;

  // Read mux on the address just completed; used only at the eighth rise
  always @* begin
    rd_mux = reg_read(word[6:0]);
  end

  // =====================================================
  // Frame state machine: serial mode only
  // Idle waits for chip select low while the strap pin is low
  // Shift takes one bit at each rising serial clock edge
  // Done swallows further edges until chip select rises
  // Chip select rising during shift drops the word with no write
  // Any other state code falls back to idle
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (!par_s && !cs_n_s) begin
          state_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (cs_n_s) begin
          state_nxt = ST_IDLE;
        end else if (sck_rise && last_bit) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        // Extra clock edges are ignored until chip select rises
        if (cs_n_s) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Bit capture, soft reset request and read-back shifter
  always @(posedge mclk_in) begin
    if (srst_in) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 5'h00;
      shift_r <= 16'h0000;
      rd_data_r <= 8'h00;
      rd_active_r <= 1'b0;
      pending_rst_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE) begin
        bit_cnt_r <= 5'h00;
        rd_active_r <= 1'b0;
      end
      // Request is consumed when chip select rises; a new request in that cycle survives
      if (soft_clr) begin
        pending_rst_r <= 1'b0;
      end
      // Only the first sixteen rising edges shift data in
      if (shift_rise) begin
        shift_r <= word;
        bit_cnt_r <= bit_cnt_r + 5'h01;
        // Address complete after flag and seven bits: load read data
        if (bit_cnt_r == `ACP_ADDR_LAST && shift_r[6]) begin
          rd_data_r <= rd_mux;
          rd_active_r <= 1'b1;
        end
        // Reset bit only arms the clear; registers drop when the frame ends
        if (wr_commit && word[14:8] == `ACP_ADDR_RST) begin
          pending_rst_r <= word[`ACP_RST_BIT];
        end
      end else if (rd_active_r && sck_fall && state_r == ST_SHIFT && bit_cnt_r > `ACP_ADDR_LAST + 5'h01) begin
        rd_data_r <= {rd_data_r[6:0], 1'b0};
      end
      if (cs_rise) begin
        rd_active_r <= 1'b0;
      end
    end
  end

  // =====================================================
  // Register file; a soft reset clear at frame end beats a write in the same cycle
  always @(posedge mclk_in) begin
    if (srst_in) begin
      pwr_r <= `ACP_REG_RESET;
      tim_r <= `ACP_REG_RESET;
      drv_r <= `ACP_REG_RESET;
      fmt_r <= `ACP_REG_RESET;
    end else if (soft_clr) begin
      pwr_r <= `ACP_REG_RESET;
      tim_r <= `ACP_REG_RESET;
      drv_r <= `ACP_REG_RESET;
      fmt_r <= `ACP_REG_RESET;
    end else if (wr_commit) begin
      // Write on flag low; reads never change registers
      // Unknown addresses fall to the default arm and leave all registers alone
      case (word[14:8])
        `ACP_ADDR_PWR: pwr_r <= word[7:0];
        `ACP_ADDR_TIM: tim_r <= word[7:0];
        `ACP_ADDR_DRV: drv_r <= word[7:0];
        `ACP_ADDR_FMT: fmt_r <= word[7:0];
        default: pwr_r <= pwr_r;
      endcase
    end
  end

  // =====================================================
  // Open-drain output: pulls low for a zero bit, otherwise released
  // The line is never driven high; a one is the host's pull-up
  // Registered so that the enable cannot glitch while the host samples
  // Strap mode never starts a frame, so the line stays released there
  always @(posedge mclk_in) begin
    if (srst_in) begin
      sdo_oe_out <= 1'b0;
    end else begin
      sdo_oe_out <= rd_active_r && !cs_n_s && (bit_cnt_r > `ACP_ADDR_LAST) && !rd_data_r[7];
    end
  end
  assign sdo_out = 1'b0;

  // =====================================================
  // Mode outputs: strap pins in parallel mode, registers in serial mode
  // Registers keep their contents in strap mode and take over again on leaving it
  // Outputs follow a pin three clocks late and a register one clock late
  always @(posedge mclk_in) begin
    if (srst_in) begin
      power_state_field_out <= `ACP_PWR_NORMAL;
      duty_stabilizer_enable_out <= 1'b0;
      out_clock_invert_out <= 1'b0;
      out_clock_delay_field_out <= 2'h0;
      diff_drive_current_field_out <= `ACP_CUR_DEFAULT;
      internal_termination_enable_out <= 1'b0;
      drive_current_boost_out <= 1'b0;
      output_high_z_out <= 1'b0;
      output_interface_select_out <= `ACP_MODE_CMOS;
    end else if (par_s) begin
      duty_stabilizer_enable_out <= cs_n_s;
      output_interface_select_out <= strap_iface;
      diff_drive_current_field_out <= `ACP_CUR_DEFAULT;
      internal_termination_enable_out <= 1'b0;
      drive_current_boost_out <= 1'b0;
      power_state_field_out <= strap_power;
      out_clock_invert_out <= 1'b0;
      out_clock_delay_field_out <= 2'h0;
      output_high_z_out <= 1'b0;
    end else begin
      power_state_field_out <= pwr_r[1:0];
      out_clock_invert_out <= tim_r[`ACP_TIM_INV];
      duty_stabilizer_enable_out <= tim_r[`ACP_TIM_DCS];
      out_clock_delay_field_out <= tim_r[`ACP_TIM_DLY_HI:`ACP_TIM_DLY_LO];
      diff_drive_current_field_out <= drv_r[`ACP_DRV_CUR_HI:`ACP_DRV_CUR_LO];
      internal_termination_enable_out <= drv_r[`ACP_DRV_TERM];
      drive_current_boost_out <= drv_r[`ACP_DRV_TERM];
      output_high_z_out <= drv_r[`ACP_DRV_HIZ];
      output_interface_select_out <= drv_r[`ACP_DRV_MODE_HI:`ACP_DRV_MODE_LO];
    end
  end

  // =====================================================
  // Data formatter; strap mode leaves all format bits clear
  // Strap mode therefore gives plain offset binary with no pattern
  acp_format u_format (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .sample_valid_in(sample_valid_in),
    .sample_in(sample_in),
    .range_overflow_flag_in(range_overflow_flag_in),
    .test_pattern_select_in(par_s ? `ACP_TP_OFF : fmt_r[`ACP_FMT_TP_HI:`ACP_FMT_TP_LO]),
    .odd_bit_invert_enable_in(~par_s & fmt_r[`ACP_FMT_ABP]),
    .lsb_scramble_enable_in(~par_s & fmt_r[`ACP_FMT_LSB_SCRAMBLE_ENABLE]),
    .signed_format_select_in(~par_s & fmt_r[`ACP_FMT_TWOS]),
    .fmt_data_out(fmt_data_out),
    .fmt_overflow_out(fmt_overflow_out)
  );
endmodule // acp_mode_port

// *** verification/acp_mode_checker.sv ***
// Checker: serial port, strap decode and reset assertions at the top ports
`timescale 1ns/1ps
module acp_mode_checker (
  input wire mclk_in,
  input wire srst_in,
  input wire strap_or_serial_select_in,
  input wire cs_n_in,
  input wire sck_in,
  input wire sdi_in,
  input wire sdo_out,
  input wire sdo_oe_out,
  input wire [1:0] power_state_field_out,
  input wire duty_stabilizer_enable_out,
  input wire [1:0] output_interface_select_out,
  input wire [2:0] diff_drive_current_field_out,
  input wire internal_termination_enable_out,
  input wire drive_current_boost_out,
  input wire output_high_z_out
);
  // Strap level and the mode outputs other than the boost, clock invert and clock delay gathered for short properties
  wire st = strap_or_serial_select_in;
  wire [9:0] modes = {power_state_field_out, duty_stabilizer_enable_out, output_interface_select_out,
                      diff_drive_current_field_out, internal_termination_enable_out, output_high_z_out};
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  // ==========================================
  // Assertions
  // Eight stable cycles cover the pin synchronisers with margin
  sdo_low_a: assert property (sdo_out == 1'b0)
    else $error("sdo data not low");
  sdo_idle_a: assert property (cs_n_in [*8] |-> !sdo_oe_out)
    else $error("sdo pulled outside a frame");
  strap_sdo_a: assert property (st [*8] |-> !sdo_oe_out)
    else $error("sdo pulled in strap mode");
  strap_dcs_a: assert property ((st && $stable(cs_n_in)) [*8] |-> duty_stabilizer_enable_out == cs_n_in)
    else $error("strap duty stabilizer wrong");
  strap_iface_a: assert property ((st && $stable(sck_in)) [*8] |->
    output_interface_select_out == {1'b0, sck_in} && diff_drive_current_field_out == 3'h0 && !internal_termination_enable_out)
    else $error("strap output mode wrong");
  strap_power_a: assert property ((st && $stable(sdi_in)) [*8] |-> power_state_field_out == {2{sdi_in}})
    else $error("strap power state wrong");
  boost_term_a: assert property (drive_current_boost_out == internal_termination_enable_out)
    else $error("boost differs from termination");
  reset_clear_a: assert property (disable iff (1'b0) srst_in |=> modes == 10'h000 && !sdo_oe_out)
    else $error("outputs not clear after reset");
  frame_quiet_a: assert property ((!st && cs_n_in) [*8] |=> $stable(modes))
    else $error("mode changed outside a frame");
  // Main scenarios reached
  strap_sleep_c: cover property (st && power_state_field_out == 2'h3);
  read_bit_c: cover property ($rose(sdo_oe_out));
  high_z_c: cover property ($rose(output_high_z_out));
endmodule // acp_mode_checker

bind acp_mode_port acp_mode_checker u_chk (.mclk_in, .srst_in, .strap_or_serial_select_in, .cs_n_in, .sck_in, .sdi_in,
  .sdo_out, .sdo_oe_out, .power_state_field_out, .duty_stabilizer_enable_out, .output_interface_select_out,
  .diff_drive_current_field_out, .internal_termination_enable_out, .drive_current_boost_out, .output_high_z_out);

// *** verification/acp_host_model.sv ***
// Host model: drives the serial configuration port and strap pins
`timescale 1ns/1ps
module acp_host_model (
  input wire mclk_in,
  input wire sdo_line_in,
  output reg cs_n_out,
  output reg sck_out,
  output reg sdi_out
);
  reg [7:0] rd_r;
  // Idle: deselected, serial clock parked low
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    sdi_out = 1'b0;
    rd_r = 8'h00;
  end
  // Step n edges, then just past the edge
  task tick(input integer n);
    begin
      repeat (n) @(posedge mclk_in);
      #1;
    end
  endtask
  // One frame of nrise 800 ns clocks; fewer than 16 aborts the word
  task frame(input [15:0] w, input integer nrise);
    integer i;
    begin
      tick(1);
      cs_n_out = 1'b0;
      for (i = 0; i < nrise; i = i + 1) begin
        sdi_out = (i < 16) ? w[15 - i] : ~sdi_out;
        tick(4);
        sck_out = 1'b1;
        tick(4);
        // Read bit stands through the high phase, so take it before the fall
        if (i >= 8 && i < 16) rd_r = {rd_r[6:0], sdo_line_in};
        sck_out = 1'b0;
      end
      tick(4);
      cs_n_out = 1'b1;
      sdi_out = ~sdi_out; // Released line must not keep the last bit
      tick(6);
    end
  endtask
  // Static strap levels
  task pins(input c, input k, input d);
    begin
      tick(1);
      cs_n_out = c;
      sck_out = k;
      sdi_out = d;
    end
  endtask
endmodule // acp_host_model

// *** verification/tb_top.sv ***
// Testbench: register access, strap decode and output formatting
`timescale 1ns/1ps
module tb_top;
  reg mclk_in = 1'b0;
  reg srst_in = 1'b1;
  reg strap;
  reg sv;
  reg [12:0] smp;
  reg [12:0] g1, g2, e;
  reg [7:0] f;
  wire cs_n, sck, sdi, sdo, sdo_oe, hiz, duty_stabilizer_enable, inv, term, boost, fo;
  wire [1:0] pwr, dly, mode;
  wire [2:0] cur;
  wire [11:0] fd;
  wire [12:0] modes = {pwr, duty_stabilizer_enable, inv, dly, cur, term, hiz, mode};
  wire sdo_line = sdo_oe ? sdo : 1'b1; // Pull-up when released
  integer err_count = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer k;
  // Format codes: plain, each modifier, pattern overrides
  localparam [79:0] FMTS = 80'h00_01_02_04_05_07_0B_1F_2F_3B;
  initial begin
    forever #50 mclk_in = ~mclk_in;
  end
  acp_mode_port dut (.mclk_in(mclk_in), .srst_in(srst_in), .strap_or_serial_select_in(strap), .cs_n_in(cs_n),
    .sck_in(sck), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .sample_valid_in(sv), .sample_in(smp[11:0]),
    .range_overflow_flag_in(smp[12]), .fmt_data_out(fd), .fmt_overflow_out(fo), .power_state_field_out(pwr),
    .duty_stabilizer_enable_out(duty_stabilizer_enable), .out_clock_invert_out(inv), .out_clock_delay_field_out(dly),
    .diff_drive_current_field_out(cur), .internal_termination_enable_out(term), .drive_current_boost_out(boost),
    .output_high_z_out(hiz), .output_interface_select_out(mode));
  acp_host_model host (.mclk_in(mclk_in), .sdo_line_in(sdo_line), .cs_n_out(cs_n), .sck_out(sck), .sdi_out(sdi));
  // ==========================================
  // Shared tasks
  task chk(input string nm, input [12:0] ex, input [12:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== ex) begin
        err_count = err_count + 1;
        $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
    end
  endtask
  task wr(input [6:0] a, input [7:0] d);
    host.frame({1'b0, a, d}, 16);
  endtask
  // Read with junk data bits that must not be stored
  task rdc(input [6:0] a, input [7:0] ex);
    begin
      host.frame({1'b1, a, 8'h5A}, 16);
      chk("readback", {5'h00, ex}, {5'h00, host.rd_r});
    end
  endtask
  task samp(input [12:0] v, output [12:0] got);
    begin
      host.tick(1);
      smp = v;
      sv = 1'b1;
      host.tick(1);
      sv = 1'b0;
      got = {fo, fd};
    end
  endtask
  // Expected word: offset flip, then scramble, then odd-bit invert
  function [12:0] fexp(input [7:0] c, input [12:0] s);
    reg [11:0] d;
    begin
      d = s[11:0];
      if (c[0] && !c[2]) d[11] = ~d[11];
      if (c[1]) d[11:1] = d[11:1] ^ {11{d[0]}};
      if (c[2]) d = d ^ 12'hAAA;
      fexp = (c[5:3] == 3'h1) ? 13'h0000 : (c[5:3] == 3'h3) ? 13'h1FFF : {s[12], d};
    end
  endfunction
  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // ==========================================
  // Scenarios
  task t_reset;
    begin
      chk("modes", 13'h0000, modes);
      wr(7'h00, 8'h80);
      for (k = 0; k < 5; k = k + 1) rdc(k[6:0], 8'h00);
    end
  endtask
  // Every field code; reads in between would corrupt outputs if stored
  task t_fields;
    for (k = 0; k < 8; k = k + 1) begin
      wr(7'h03, {1'b0, k[2:0], k[0], k[2], k[1:0]});
      wr(7'h02, {4'h0, k[2], k[1:0], (k[1:0] != 2'h0) || k[2]});
      wr(7'h01, {6'h00, k[1:0]});
      rdc(7'h03, {1'b0, k[2:0], k[0], k[2], k[1:0]});
      rdc(7'h02, {4'h0, k[2], k[1:0], (k[1:0] != 2'h0) || k[2]});
      chk("driver", {5'h00, k[2:0], k[0], k[0], k[2], k[1:0]}, {5'h00, cur, term, boost, hiz, mode});
      chk("timing", {7'h00, k[2], k[1:0], (k[1:0] != 2'h0) || k[2], k[1:0]}, {7'h00, inv, dly, duty_stabilizer_enable, pwr});
    end
  endtask
  task t_frame;
    begin
      host.frame({1'b0, 7'h02, 8'h0B}, 20);
      rdc(7'h02, 8'h0B);
      host.frame({1'b0, 7'h02, 8'h00}, 12);
      rdc(7'h02, 8'h0B);
      wr(7'h05, 8'hFF);
      rdc(7'h05, 8'h00);
      wr(7'h00, 8'h80);
      chk("cleared", 13'h0000, modes);
      rdc(7'h02, 8'h00);
    end
  endtask
  task t_strap;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        host.pins(k[2], k[1], k[0]);
        strap = 1'b1;
        host.tick(8);
        chk("strap", {4'h0, k[2], 1'b0, k[1], 4'h0, k[0], k[0]}, {4'h0, duty_stabilizer_enable, mode, cur, term, pwr});
      end
      host.pins(1'b1, 1'b0, 1'b0);
      strap = 1'b0;
      host.tick(8);
    end
  endtask
  task t_format;
    begin
      wr(7'h01, 8'h01);
      wr(7'h01, 8'h00);
      host.tick(100); // Wake-up settling before samples are used
      for (k = 0; k < 10; k = k + 1) begin
        f = FMTS[79 - 8 * k -: 8];
        wr(7'h04, f);
        samp(13'h06C5, g1);
        samp(13'h1B3A, g2);
        if (f[5:3] == 3'h5 || f[5:3] == 3'h7) begin
          e = f[4] ? 13'h0000 : 13'h1555;
          chk("pattern", e, (g1 === ~e) ? e : g1);
          chk("pattern", ~g1, g2);
        end else begin
          chk("format", fexp(f, 13'h06C5), g1);
          chk("format", fexp(f, 13'h1B3A), g2);
        end
      end
    end
  endtask
  // ==========================================
  // Main sequence and hang guard
  initial begin
    strap = 1'b0;
    sv = 1'b0;
    smp = 13'h0000;
    host.tick(16);
    srst_in = 1'b0;
    host.tick(4);
    t_reset;
    t_fields;
    t_frame;
    t_strap;
    t_format;
    test_done;
  end
  always @(posedge mclk_in) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      test_done;
    end
  end
endmodule // tb_top
